//--- rtl/reset_and_test_port_select.sv
// Reset release timing, shared pin mux and boundary scan test port
`timescale 1ns/100ps
`include "rst_test_consts.svh"
module reset_and_test_port_select (
  input  wire logic       CLK,         // System clock, 125 MHz
  input  wire logic       RST,         // Synchronous power-on reset
  input  wire logic       RESET_N,     // Device reset pin, also test reset
  input  wire logic       TEST_SEL,    // High selects boundary scan port
  input  wire logic       PIN_CS_TMS,  // Shared pin: chip select or TMS
  input  wire logic       PIN_SCK_TCK, // Shared pin: serial clock or TCK
  input  wire logic       PIN_SDI_TDI, // Shared pin: serial in or TDI
  output logic            PIN_SDO_TDO, // Shared pin: serial out or TDO
  output logic            PIN_SDO_OE,  // Output enable of shared out pin
  input  wire logic       CORE_LOCK,   // Core lock indicator
  input  wire logic [9:0] CORE_DATA,   // Core parallel data
  output logic            SIGNAL_LOCK_INDICATOR, // Lock pin
  output logic [9:0]      DATA_OUT,    // Parallel data pins
  output logic            CFG_CS_N,    // To serial config port: select
  output logic            CFG_SCK,     // To serial config port: clock
  output logic            CFG_SDI,     // To serial config port: data
  output logic            CFG_RESET,   // Config registers back to defaults
  output logic            OUT_VALID,   // Outputs settled after release
  output logic            RESET_SHORT  // Last reset pulse under 1ms
);
  // How the block is meant to be used:
  // The mode pin is a level; the host changes it only while the port is idle,
  // because switching mid-frame leaves the config port with a cut transfer.
  // The test clock is sampled by the system clock, so each of its phases
  // must last at least one system clock or an edge is lost.
  // The reset pin acts synchronously here; the pad ring is expected to
  // align it to the system clock before it reaches this block.
  // The lock and data pins are held at zero through reset and then follow
  // the core one cycle late, or the boundary cells under extest; the settling flag tells the host when to look.
  // The short-reset flag is only a status: the block does not stretch a
  // short pulse, it reports it so that software can repeat the reset.
  // Limitation: no identification register, so an unknown instruction
  // behaves like sample and keeps the pins on the core values.

  // Settling and reset length bookkeeping
  logic [31:0] settle_q;
  logic [31:0] low_cnt_q;
  logic        rst_pin_q;
  logic        short_q;

  // Test clock edge detection, kept with the pin steering
  logic        tck_q;
  logic        tck_rise;
  logic        tck_fall;

  // Either reset source clears the state on in_reset; tck_q and the length monitor take RST only
  logic        in_reset;

  // Test controller and its registers
  rst_test_pkg::tap_state_t tap_q;
  rst_test_pkg::tap_state_t tap_d;
  logic [3:0]  ir_q;
  logic [3:0]  ir_sh_q;
  logic        byp_q;
  logic [`BSR_LEN-1:0] bsr_q;
  logic [`BSR_LEN-1:0] bsr_upd_q;
  logic        tdo_q;

  // Boundary cells own the output pins only under extest
  logic        extest;

  // Reset and pin decode; reset is a plain level, the test clock is decoded into rise and fall edges
  assign in_reset = RST | ~RESET_N;
  assign tck_rise = TEST_SEL & PIN_SCK_TCK & ~tck_q;
  assign tck_fall = TEST_SEL & ~PIN_SCK_TCK & tck_q;
  assign extest   = TEST_SEL & (ir_q == `IR_EXTEST);
  assign CFG_RESET = in_reset;

  // Settling counter; OUT_VALID stays low until it expires, which lets the host rely on
  always_ff @(posedge CLK) begin
    if (in_reset) begin
      settle_q <= 32'h0;
    end else if (settle_q < `SETTLE_CYCLES - 32'd1) begin
      settle_q <= settle_q + 32'h1;
    end
  end
  assign OUT_VALID = ~in_reset & (settle_q == `SETTLE_CYCLES - 32'd1);

  // Reset length monitor: flags a release that came sooner than the minimum hold
  always_ff @(posedge CLK) begin
    if (RST) begin
      low_cnt_q <= 32'h0;
      rst_pin_q <= 1'b1;
      short_q   <= 1'b0;
    end else begin
      rst_pin_q <= RESET_N;
      if (!RESET_N && low_cnt_q != 32'hffffffff) begin
        low_cnt_q <= low_cnt_q + 32'h1;
      end else if (RESET_N && !rst_pin_q) begin
        short_q   <= (low_cnt_q < `RESET_MIN_CYCLES);
        low_cnt_q <= 32'h0;
      end
    end
  end
  assign RESET_SHORT = short_q;

  // Data outputs: registered, driven from the boundary cells under extest
  always_ff @(posedge CLK) begin
    if (in_reset) begin
      SIGNAL_LOCK_INDICATOR <= 1'b0;
      DATA_OUT              <= 10'h000;
    end else if (extest) begin
      SIGNAL_LOCK_INDICATOR <= bsr_upd_q[10];
      DATA_OUT              <= bsr_upd_q[9:0];
    end else begin
      SIGNAL_LOCK_INDICATOR <= CORE_LOCK;
      DATA_OUT              <= CORE_DATA;
    end
  end

  // Pin steering; config port idles deselected while in test mode
  always_comb begin
    if (TEST_SEL) begin
      CFG_CS_N    = 1'b1;
      CFG_SCK     = 1'b0;
      CFG_SDI     = 1'b0;
      PIN_SDO_TDO = tdo_q;
      PIN_SDO_OE  = (tap_q == rst_test_pkg::SH_DR) || (tap_q == rst_test_pkg::SH_IR);
    end else begin
      CFG_CS_N    = PIN_CS_TMS;
      CFG_SCK     = PIN_SCK_TCK;
      CFG_SDI     = PIN_SDI_TDI;
      PIN_SDO_TDO = PIN_SDI_TDI; // Loop-through, no clocking
      PIN_SDO_OE  = 1'b1;
    end
  end

  // Test clock edge detect; TCK is far slower than CLK
  always_ff @(posedge CLK) begin
    if (RST) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= PIN_SCK_TCK;
    end
  end

  // Test controller next state, standard sixteen-state walk on TMS
  always_comb begin
    tap_d = tap_q;
    case (tap_q)
      rst_test_pkg::TLR:    tap_d = PIN_CS_TMS ? rst_test_pkg::TLR : rst_test_pkg::RTI;
      rst_test_pkg::RTI:    tap_d = PIN_CS_TMS ? rst_test_pkg::SEL_DR : rst_test_pkg::RTI;
      rst_test_pkg::SEL_DR: tap_d = PIN_CS_TMS ? rst_test_pkg::SEL_IR : rst_test_pkg::CAP_DR;
      rst_test_pkg::CAP_DR: tap_d = PIN_CS_TMS ? rst_test_pkg::EX1_DR : rst_test_pkg::SH_DR;
      rst_test_pkg::SH_DR:  tap_d = PIN_CS_TMS ? rst_test_pkg::EX1_DR : rst_test_pkg::SH_DR;
      rst_test_pkg::EX1_DR: tap_d = PIN_CS_TMS ? rst_test_pkg::UPD_DR : rst_test_pkg::PA_DR;
      rst_test_pkg::PA_DR:  tap_d = PIN_CS_TMS ? rst_test_pkg::EX2_DR : rst_test_pkg::PA_DR;
      rst_test_pkg::EX2_DR: tap_d = PIN_CS_TMS ? rst_test_pkg::UPD_DR : rst_test_pkg::SH_DR;
      rst_test_pkg::UPD_DR: tap_d = PIN_CS_TMS ? rst_test_pkg::SEL_DR : rst_test_pkg::RTI;
      rst_test_pkg::SEL_IR: tap_d = PIN_CS_TMS ? rst_test_pkg::TLR : rst_test_pkg::CAP_IR;
      rst_test_pkg::CAP_IR: tap_d = PIN_CS_TMS ? rst_test_pkg::EX1_IR : rst_test_pkg::SH_IR;
      rst_test_pkg::SH_IR:  tap_d = PIN_CS_TMS ? rst_test_pkg::EX1_IR : rst_test_pkg::SH_IR;
      rst_test_pkg::EX1_IR: tap_d = PIN_CS_TMS ? rst_test_pkg::UPD_IR : rst_test_pkg::PA_IR;
      rst_test_pkg::PA_IR:  tap_d = PIN_CS_TMS ? rst_test_pkg::EX2_IR : rst_test_pkg::PA_IR;
      rst_test_pkg::EX2_IR: tap_d = PIN_CS_TMS ? rst_test_pkg::UPD_IR : rst_test_pkg::SH_IR;
      rst_test_pkg::UPD_IR: tap_d = PIN_CS_TMS ? rst_test_pkg::SEL_DR : rst_test_pkg::RTI;
      default:              tap_d = rst_test_pkg::TLR;
    endcase
  end

  // Controller state; the reset pin doubles as test reset
  always_ff @(posedge CLK) begin
    if (in_reset || !TEST_SEL) begin
      tap_q <= rst_test_pkg::TLR;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // Instruction and data registers, shifted on rising TCK
  always_ff @(posedge CLK) begin
    if (in_reset || !TEST_SEL || tap_q == rst_test_pkg::TLR) begin
      ir_q      <= `IR_BYPASS;
      ir_sh_q   <= 4'h0;
      byp_q     <= 1'b0;
      bsr_q     <= '0;
      bsr_upd_q <= '0;
    end else if (tck_rise) begin
      case (tap_q)
        rst_test_pkg::CAP_IR: ir_sh_q <= `IR_RESET;
        rst_test_pkg::SH_IR:  ir_sh_q <= {PIN_SDI_TDI, ir_sh_q[3:1]};
        rst_test_pkg::CAP_DR: begin
          byp_q <= 1'b0;
          bsr_q <= {CORE_LOCK, CORE_DATA};
        end
        rst_test_pkg::SH_DR: begin
          byp_q <= PIN_SDI_TDI;
          if (ir_q != `IR_BYPASS) begin
            bsr_q <= {PIN_SDI_TDI, bsr_q[`BSR_LEN-1:1]};
          end
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      if (tap_q == rst_test_pkg::UPD_IR) begin
        ir_q <= ir_sh_q;
      end
      if (tap_q == rst_test_pkg::UPD_DR) begin
        bsr_upd_q <= bsr_q;
      end
    end
  end

  // Test data out changes on falling TCK, as the port requires
  always_ff @(posedge CLK) begin
    if (in_reset) begin
      tdo_q <= 1'b0;
    end else if (tck_fall) begin
      if (tap_q == rst_test_pkg::SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (ir_q == `IR_BYPASS) begin
        tdo_q <= byp_q;
      end else begin
        tdo_q <= bsr_q[0];
      end
    end
  end
endmodule : reset_and_test_port_select

//--- rtl/rst_test_consts.svh
// Constants for the reset release and test port select block
`ifndef RST_TEST_CONSTS_SVH
`define RST_TEST_CONSTS_SVH
`define CLK_PERIOD_PS     32'd8000
`define SETTLE_TIME_NS    32'd200
`define SETTLE_CYCLES     ((`SETTLE_TIME_NS * 32'd1000) / `CLK_PERIOD_PS)
`define RESET_MIN_TIME_US 32'd1000
`define RESET_MIN_CYCLES  ((`RESET_MIN_TIME_US * 32'd1000000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define IR_BYPASS         4'hf
`define IR_EXTEST         4'h0
`define IR_SAMPLE         4'h1
`define IR_RESET          4'h1
`define BSR_LEN           11
`endif

//--- rtl/rst_test_pkg.sv
// Types for the reset release and test port select block
package rst_test_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } tap_state_t;
endpackage : rst_test_pkg

//--- tb/rst_port_monitor.sv
// Checker for reset release, pin sharing and test port
`timescale 1ns/100ps
module rst_port_monitor (
  input wire logic       CLK,          // Clock
  input wire logic       RST,          // Reset
  input wire logic       RESET_N,      // Reset pin
  input wire logic       TEST_SEL,     // Mode pin
  input wire logic       PIN_CS_TMS,   // Shared pin
  input wire logic       PIN_SCK_TCK,  // Shared pin
  input wire logic       PIN_SDI_TDI,  // Shared pin
  input wire logic       PIN_SDO_TDO,  // Shared out
  input wire logic       PIN_SDO_OE,   // Out enable
  input wire logic       CORE_LOCK,    // Core lock
  input wire logic [9:0] CORE_DATA,    // Core data
  input wire logic       SIGNAL_LOCK_INDICATOR, // Lock out
  input wire logic [9:0] DATA_OUT,     // Data out
  input wire logic       CFG_CS_N,     // Port select
  input wire logic       CFG_SCK,      // Port clock
  input wire logic       CFG_SDI,      // Port data
  input wire logic       CFG_RESET,    // Config reset
  input wire logic       OUT_VALID     // Settled
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_CFG_MUX: assert property (!TEST_SEL |-> CFG_CS_N == PIN_CS_TMS &&
    CFG_SCK == PIN_SCK_TCK && CFG_SDI == PIN_SDI_TDI) else $error("config pins not passed");
  AST_LOOP: assert property (!TEST_SEL |-> PIN_SDO_OE && PIN_SDO_TDO == PIN_SDI_TDI)
    else $error("serial loop-through broken");
  AST_TEST_PARK: assert property (TEST_SEL |-> CFG_CS_N && !CFG_SCK && !CFG_SDI)
    else $error("config port not parked in test mode");
  AST_CFG_RST: assert property (CFG_RESET == !RESET_N) else $error("config reset wrong");
  AST_SETTLE: assert property ($rose(RESET_N) |-> (!OUT_VALID throughout (1'b1 ##23 1'b1))
    ##1 OUT_VALID) else $error("settle time wrong");
  AST_DATA: assert property (OUT_VALID && !TEST_SEL |-> DATA_OUT == $past(CORE_DATA) &&
    SIGNAL_LOCK_INDICATOR == $past(CORE_LOCK)) else $error("data does not follow core");
  AST_ZERO: assert property (!RESET_N |=> DATA_OUT == 10'h000 && !SIGNAL_LOCK_INDICATOR)
    else $error("outputs not cleared in reset");
  AST_TAP_RST: assert property (TEST_SEL && !RESET_N ##1 TEST_SEL |-> !PIN_SDO_OE)
    else $error("test port not reset");
  cover property ($rose(OUT_VALID));
  cover property (TEST_SEL && PIN_SDO_OE);
  cover property (TEST_SEL && !RESET_N);
endmodule : rst_port_monitor

//--- tb/host_model.sv
// Host or tester driving the shared pins
`timescale 1ns/100ps
module host_model (
  input wire logic clk,  // Clock
  output logic     tms,  // Select or TMS
  output logic     tck,  // Serial clock or TCK, still between frames
  output logic     tdi,  // Serial in or TDI
  input wire logic tdo   // Serial out or TDO, read live at the sample point
);
  initial {tms, tck, tdi} = 3'h0;
  // Random config traffic, only legal while mode pin is low
  task automatic cfg_rand();
    @(negedge clk) {tms, tck, tdi} = 3'($urandom);
  endtask : cfg_rand
  // One test clock; phases kept long so the edge detector sees both
  task automatic tick(input logic ms, input logic di, output logic d_o);
    @(negedge clk) {tms, tdi, tck} = {ms, di, 1'b0};
    repeat (3) @(negedge clk);
    d_o = tdo;
    tck = 1'b1;
    repeat (3) @(negedge clk);
    tck = 1'b0;
  endtask : tick
endmodule : host_model

//--- tb/tb_reset_and_test_port_select.sv
// Top bench for the reset and test port select block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_reset_and_test_port_select;
  logic CLK, RST, RESET_N, TEST_SEL, PIN_CS_TMS, PIN_SCK_TCK, PIN_SDI_TDI, PIN_SDO_TDO;
  logic PIN_SDO_OE, CORE_LOCK, SIGNAL_LOCK_INDICATOR, CFG_CS_N, CFG_SCK, CFG_SDI;
  logic CFG_RESET, OUT_VALID, RESET_SHORT, d_o, prev, b;
  logic [9:0] CORE_DATA, DATA_OUT;
  logic [10:0] exp_q[$];
  logic [10:0] pat;
  int miscompares = 0, checks = 0, n;
  reset_and_test_port_select reset_and_test_port_select_i (
    .CLK(CLK), .RST(RST), .RESET_N(RESET_N), .TEST_SEL(TEST_SEL), .PIN_CS_TMS(PIN_CS_TMS),
    .PIN_SCK_TCK(PIN_SCK_TCK), .PIN_SDI_TDI(PIN_SDI_TDI), .PIN_SDO_TDO(PIN_SDO_TDO),
    .PIN_SDO_OE(PIN_SDO_OE), .CORE_LOCK(CORE_LOCK), .CORE_DATA(CORE_DATA),
    .SIGNAL_LOCK_INDICATOR(SIGNAL_LOCK_INDICATOR), .DATA_OUT(DATA_OUT), .CFG_CS_N(CFG_CS_N),
    .CFG_SCK(CFG_SCK), .CFG_SDI(CFG_SDI), .CFG_RESET(CFG_RESET), .OUT_VALID(OUT_VALID),
    .RESET_SHORT(RESET_SHORT));
  host_model host_model_i (.clk(CLK), .tms(PIN_CS_TMS), .tck(PIN_SCK_TCK), .tdi(PIN_SDI_TDI),
    .tdo(PIN_SDO_TDO));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Clock out TMS and TDI patterns, bit 0 first; the last TDO sample stays in d_o
  task automatic walk(input logic [15:0] ms, input logic [15:0] di, input int len);
    for (int i = 0; i < len; i++) begin
      host_model_i.tick(ms[i], di[i], d_o);
    end
  endtask : walk
  // Watcher: registered outputs are compared just after the edge that loads them
  always @(posedge CLK) begin
    #1;
    if (exp_q.size() > 0) `CHK({SIGNAL_LOCK_INDICATOR, DATA_OUT}, exp_q.pop_front())
  end
  initial begin
    {RST, RESET_N, TEST_SEL, CORE_LOCK, CORE_DATA} = {3'h4, 11'h000};
    void'($urandom(75));
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    repeat (8) @(negedge CLK);
    RESET_N = 1'b1; // shortened: only a status flag depends on the full hold
    for (n = 0; n < 40 && OUT_VALID !== 1'b1; n++) @(negedge CLK);
    `CHK(n, 24)
    if (n == 40) end_sim();
    `CHK(RESET_SHORT, 1'b1)
    repeat (20) begin
      @(negedge CLK) {CORE_LOCK, CORE_DATA} = 11'($urandom);
      exp_q.push_back({CORE_LOCK, CORE_DATA});
      host_model_i.cfg_rand();
    end
    @(negedge CLK) TEST_SEL = 1'b1;
    @(negedge CLK) `CHK({CFG_CS_N, CFG_SCK, CFG_SDI}, 3'h4)
    // Reset the port, then walk to shift-DR with bypass selected
    walk(16'h001f, 16'h0000, 5);
    walk(16'h0002, 16'h0000, 4);
    prev = 1'b0;
    repeat (8) begin
      b = 1'($urandom);
      host_model_i.tick(1'b0, b, d_o);
      `CHK(d_o, prev)
      prev = b;
    end
    // Load extest through the instruction path, then drive the pins from the cells
    walk(16'h000f, 16'h0000, 6);
    host_model_i.tick(1'b0, 1'b0, d_o);
    `CHK(d_o, 1'b1)
    walk(16'h001c, 16'h0000, 7);
    pat = 11'($urandom);
    walk(16'h0400, {5'h00, pat}, 11);
    walk(16'h0001, 16'h0000, 2);
    repeat (2) @(negedge CLK);
    `CHK({SIGNAL_LOCK_INDICATOR, DATA_OUT}, pat)
    @(negedge CLK) RESET_N = 1'b0;
    repeat (2) @(negedge CLK);
    `CHK({CFG_RESET, PIN_SDO_OE}, 2'h2)
    {RESET_N, TEST_SEL} = 2'h2;
    repeat (30) @(negedge CLK);
    end_sim();
  end
endmodule : tb_reset_and_test_port_select
bind reset_and_test_port_select rst_port_monitor rst_port_monitor_i (.*);
